// [rtl/bt_hci_uart_transport.sv]
// HCI serial transport: rate control, autobaud, buffered receiver and transmitter
//
// Contract
// - Four lines: serial in, serial out, request-to-send out, clear-to-send in.
// - Rate settable from 9600 bps up to 4.0 Mbps.
// - Line-rate detector measures incoming start bit and yields a rate selection.
// - Host may instead pick the rate through a vendor command.
// - Separate 1040-byte receive and transmit buffers.
// - Both buffers reachable from the internal bus by DMA or processor; the code has no bus port, only the tx_push/tx_word and rx_pop/rx_word ports.
// - Carries H4, extended H4 or H5 traffic as configured.
// - Runs at 115.2 kbaud until reconfigured.
// - In H5 both sides ignore request-to-send and clear-to-send.
// - XOFF pauses transmission, XON resumes it.
// - Hardware SLIP delimiting and escaping for H5.
// - While asleep, activity on serial in or clear-to-send raises wake.
// - After reset the rate comes from a configuration record or detection.
// - Vendor command rewrites the rate registers during operation.
// - Combined rate error of both ends stays within two percent.
// - Valid data on serial out within 1.5 bits of clear-to-send low.
// - Request-to-send rises within half a bit after received stop midpoint.
`timescale 1ns/1ps
`default_nettype none

module bt_hci_uart_transport (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   rxd,
  output logic                        txd,
  input  wire logic                   cts_n,
  output logic                        rts_n,
  input  wire bt_uart_pkg::cfg_t      cfg,
  input  wire bt_uart_pkg::rate_cmd_t rate_cmd,
  input  wire logic                   ab_arm,
  output logic                        baud_found,
  output logic [15:0]                 baud_sel,
  output logic [15:0]                 bit_divisor,
  input  wire logic                   tx_push,
  input  wire bt_uart_pkg::fifo_word_t tx_word,
  output logic                        tx_ready,
  output logic                        rx_valid,
  output var bt_uart_pkg::fifo_word_t rx_word,
  input  wire logic                   rx_pop,
  output logic                        rx_drop,
  output logic                        tx_paused,
  input  wire logic                   sleep,
  output logic                        wake
);

  bt_uart_pkg::state_t st;
  bt_uart_pkg::state_t n;

  // Keep any rate inside the supported span
  function automatic logic [15:0] clamp_div(input logic [15:0] d);
    if (d < bt_uart_pkg::DIV_MIN)
      return bt_uart_pkg::DIV_MIN;
    if (d > bt_uart_pkg::DIV_MAX)
      return bt_uart_pkg::DIV_MAX;
    return d;
  endfunction : clamp_div

  // Circular buffer pointer advance
  function automatic logic [10:0] ptr_inc(input logic [10:0] p);
    return (p == bt_uart_pkg::PTR_LAST) ? 11'h000 : p + bt_uart_pkg::PTR_ONE;
  endfunction : ptr_inc

  // Next-state logic for the whole block
  always_comb
  begin
    logic                    h5;
    logic                    slip;
    logic                    cts_ok;
    logic                    rx_done;
    logic                    rx_push;
    logic                    rx_take;
    logic                    tx_take;
    logic                    tx_pop;
    logic [7:0]              b;
    bt_uart_pkg::fifo_word_t w;
    bt_uart_pkg::fifo_word_t tw;
    n       = st;
    h5      = (cfg.mode == bt_uart_pkg::TP_H5);
    slip    = h5 && cfg.slip_en;
    cts_ok  = h5 || !cts_n;
    rx_done = 1'b0;
    rx_push = 1'b0;
    rx_take = 1'b0;
    tx_take = 1'b0;
    tx_pop  = 1'b0;
    b       = st.rx_shift;
    w       = '{delim: 1'b0, data: st.rx_shift};
    tw      = st.tx_mem[st.tx_rd];

    // Rate load from configuration record or vendor command
    n.baud_found = 1'b0;
    if (rate_cmd.load)
      n.divisor = clamp_div(rate_cmd.divisor);

    // Line-rate detector: width of the first low pulse in clocks
    if (ab_arm)
    begin
      n.ab_armed = 1'b1;
      n.ab_low   = 1'b0;
      n.ab_cnt   = '0;
    end
    else if (st.ab_armed)
    begin
      if (!st.ab_low)
      begin
        if (!rxd)
        begin
          n.ab_low = 1'b1;
          n.ab_cnt = bt_uart_pkg::CNT_ONE;
        end
      end
      else if (!rxd)
      begin
        if (st.ab_cnt != bt_uart_pkg::DIV_SAT)
          n.ab_cnt = st.ab_cnt + bt_uart_pkg::CNT_ONE;
      end
      else
      begin
        n.ab_armed   = 1'b0;
        n.ab_low     = 1'b0;
        n.divisor    = clamp_div(st.ab_cnt);
        n.baud_sel   = clamp_div(st.ab_cnt);
        n.baud_found = 1'b1;
      end
    end

    // Receiver, sampling each bit at its middle
    unique case (st.rx_state)
      bt_uart_pkg::RX_IDLE:
        if (!st.ab_armed && !rxd)
        begin
          n.rx_state = bt_uart_pkg::RX_START;
          n.rx_cnt   = st.divisor >> 1;
        end
      bt_uart_pkg::RX_START:
        if (st.rx_cnt == '0)
        begin
          n.rx_state = rxd ? bt_uart_pkg::RX_IDLE : bt_uart_pkg::RX_DATA;
          n.rx_cnt   = st.divisor - bt_uart_pkg::CNT_ONE;
          n.rx_bit   = bt_uart_pkg::BIT_FIRST;
        end
        else
          n.rx_cnt = st.rx_cnt - bt_uart_pkg::CNT_ONE;
      bt_uart_pkg::RX_DATA:
        if (st.rx_cnt == '0)
        begin
          n.rx_shift = {rxd, st.rx_shift[7:1]};
          n.rx_cnt   = st.divisor - bt_uart_pkg::CNT_ONE;
          if (st.rx_bit == bt_uart_pkg::BIT_LAST)
            n.rx_state = bt_uart_pkg::RX_STOP;
          else
            n.rx_bit = st.rx_bit + bt_uart_pkg::BIT_ONE;
        end
        else
          n.rx_cnt = st.rx_cnt - bt_uart_pkg::CNT_ONE;
      bt_uart_pkg::RX_STOP:
        if (st.rx_cnt == '0)
        begin
          n.rx_state = bt_uart_pkg::RX_IDLE;
          rx_done    = rxd;
        end
        else
          n.rx_cnt = st.rx_cnt - bt_uart_pkg::CNT_ONE;
    endcase

    // Received character: flow codes, SLIP decoding or plain store
    if (rx_done)
    begin
      if (cfg.sw_flow && (b == bt_uart_pkg::CH_XOFF))
        n.paused = 1'b1;
      else if (cfg.sw_flow && (b == bt_uart_pkg::CH_XON))
        n.paused = 1'b0;
      else if (slip && (b == bt_uart_pkg::SLIP_END))
      begin
        w       = '{delim: 1'b1, data: b};
        rx_push = 1'b1;
        n.rx_esc = 1'b0;
      end
      else if (slip && st.rx_esc)
      begin
        n.rx_esc = 1'b0;
        rx_push  = 1'b1;
        if (b == bt_uart_pkg::ESC_END)
          w.data = bt_uart_pkg::SLIP_END;
        else if (b == bt_uart_pkg::ESC_ESC)
          w.data = bt_uart_pkg::SLIP_ESC;
      end
      else if (slip && (b == bt_uart_pkg::SLIP_ESC))
        n.rx_esc = 1'b1;
      else
        rx_push = 1'b1;
    end
    if (!cfg.sw_flow)
      n.paused = 1'b0;

    // Receive buffer
    rx_take   = rx_pop && st.rx_valid;
    n.rx_drop = rx_push && (st.rx_count == bt_uart_pkg::FIFO_FULL);
    rx_push   = rx_push && !n.rx_drop;
    if (rx_push)
    begin
      n.rx_mem[st.rx_wr] = w;
      n.rx_wr            = ptr_inc(st.rx_wr);
    end
    if (rx_take)
      n.rx_rd = ptr_inc(st.rx_rd);
    n.rx_count = st.rx_count + 11'(rx_push) - 11'(rx_take);
    n.rx_valid = (n.rx_count != '0);
    n.rx_word  = n.rx_mem[n.rx_rd];

    // Flow request: drop it when nearly full, never in H5
    n.rts_n = !h5 && (n.rx_count >= bt_uart_pkg::RTS_MARK);

    // Transmitter; clear-to-send checked only between characters
    unique case (st.tx_state)
      bt_uart_pkg::TX_IDLE:
      begin
        n.txd = 1'b1;
        if (cts_ok && !st.paused)
        begin
          if (st.tx_esc_pend)
          begin
            n.tx_esc_pend = 1'b0;
            n.tx_shift    = st.tx_esc_byte;
            n.tx_state    = bt_uart_pkg::TX_START;
          end
          else if (st.tx_count != '0)
          begin
            tx_pop     = 1'b1;
            n.tx_state = bt_uart_pkg::TX_START;
            n.tx_shift = tw.data;
            if (slip && tw.delim)
              n.tx_shift = bt_uart_pkg::SLIP_END;
            else if (slip && (tw.data == bt_uart_pkg::SLIP_END))
            begin
              n.tx_shift    = bt_uart_pkg::SLIP_ESC;
              n.tx_esc_pend = 1'b1;
              n.tx_esc_byte = bt_uart_pkg::ESC_END;
            end
            else if (slip && (tw.data == bt_uart_pkg::SLIP_ESC))
            begin
              n.tx_shift    = bt_uart_pkg::SLIP_ESC;
              n.tx_esc_pend = 1'b1;
              n.tx_esc_byte = bt_uart_pkg::ESC_ESC;
            end
          end
          if (n.tx_state == bt_uart_pkg::TX_START)
          begin
            n.txd    = 1'b0;
            n.tx_cnt = st.divisor - bt_uart_pkg::CNT_ONE;
          end
        end
      end
      bt_uart_pkg::TX_START:
        if (st.tx_cnt == '0)
        begin
          n.tx_state = bt_uart_pkg::TX_DATA;
          n.tx_bit   = bt_uart_pkg::BIT_FIRST;
          n.txd      = st.tx_shift[0];
          n.tx_shift = st.tx_shift >> 1;
          n.tx_cnt   = st.divisor - bt_uart_pkg::CNT_ONE;
        end
        else
          n.tx_cnt = st.tx_cnt - bt_uart_pkg::CNT_ONE;
      bt_uart_pkg::TX_DATA:
        if (st.tx_cnt == '0)
        begin
          n.tx_cnt = st.divisor - bt_uart_pkg::CNT_ONE;
          if (st.tx_bit == bt_uart_pkg::BIT_LAST)
          begin
            n.tx_state = bt_uart_pkg::TX_STOP;
            n.txd      = 1'b1;
          end
          else
          begin
            n.tx_bit   = st.tx_bit + bt_uart_pkg::BIT_ONE;
            n.txd      = st.tx_shift[0];
            n.tx_shift = st.tx_shift >> 1;
          end
        end
        else
          n.tx_cnt = st.tx_cnt - bt_uart_pkg::CNT_ONE;
      bt_uart_pkg::TX_STOP:
        if (st.tx_cnt == '0)
          n.tx_state = bt_uart_pkg::TX_IDLE;
        else
          n.tx_cnt = st.tx_cnt - bt_uart_pkg::CNT_ONE;
    endcase

    // Transmit buffer
    tx_take = tx_push && st.tx_room;
    if (tx_take)
    begin
      n.tx_mem[st.tx_wr] = tx_word;
      n.tx_wr            = ptr_inc(st.tx_wr);
    end
    if (tx_pop)
      n.tx_rd = ptr_inc(st.tx_rd);
    n.tx_count = st.tx_count + 11'(tx_take) - 11'(tx_pop);
    n.tx_room  = (n.tx_count != bt_uart_pkg::FIFO_FULL);

    // Wake on line activity while asleep
    n.rxd_prev = rxd;
    n.cts_prev = cts_n;
    n.wake     = sleep && ((rxd != st.rxd_prev) || (cts_n != st.cts_prev));
  end

  // State register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      st <= bt_uart_pkg::ST_RESET;
    else
      st <= n;
  end

  // Outputs straight from state
  assign txd         = st.txd;
  assign rts_n       = st.rts_n;
  assign baud_found  = st.baud_found;
  assign baud_sel    = st.baud_sel;
  assign bit_divisor = st.divisor;
  assign tx_ready    = st.tx_room;
  assign rx_valid    = st.rx_valid;
  assign rx_word     = st.rx_word;
  assign rx_drop     = st.rx_drop;
  assign tx_paused   = st.paused;
  assign wake        = st.wake;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_cts_ready;
    !cts_n && (st.tx_state == bt_uart_pkg::TX_IDLE) && (st.tx_count != '0) && !st.paused;
  endsequence
  sequence s_start_bit;
    (st.tx_state == bt_uart_pkg::TX_START) && !txd;
  endsequence

  property p_rate_range;
    (st.divisor >= bt_uart_pkg::DIV_MIN) && (st.divisor <= bt_uart_pkg::DIV_MAX);
  endproperty
  a_rate_range: assert property (p_rate_range) else $error("rate out of range");

  property p_auto_load;
    st.baud_found |-> (st.divisor == st.baud_sel) && (st.baud_sel >= bt_uart_pkg::DIV_MIN);
  endproperty
  a_auto_load: assert property (p_auto_load) else $error("detected rate not applied");

  property p_cmd_load;
    rate_cmd.load && !ab_arm && !st.ab_armed |=> st.divisor == clamp_div($past(rate_cmd.divisor));
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("commanded rate not applied");

  property p_fifo_bound;
    (st.rx_count <= bt_uart_pkg::FIFO_FULL) && (st.tx_count <= bt_uart_pkg::FIFO_FULL);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count overflow");

  property p_xoff_hold;
    st.paused && (st.tx_state == bt_uart_pkg::TX_IDLE) |=> st.tx_state == bt_uart_pkg::TX_IDLE;
  endproperty
  a_xoff_hold: assert property (p_xoff_hold) else $error("sent while paused");

  property p_cts_hold;
    cts_n && (cfg.mode != bt_uart_pkg::TP_H5) && (st.tx_state == bt_uart_pkg::TX_IDLE)
      |=> st.tx_state == bt_uart_pkg::TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("started without clear-to-send");

  property p_cts_start;
    s_cts_ready |=> s_start_bit;
  endproperty
  a_cts_start: assert property (p_cts_start) else $error("late start after clear-to-send");

  property p_stop_bit;
    (st.tx_state == bt_uart_pkg::TX_STOP) |-> txd;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high");

  property p_rts_mark;
    (cfg.mode != bt_uart_pkg::TP_H5) && (n.rx_count >= bt_uart_pkg::RTS_MARK) |=> rts_n;
  endproperty
  a_rts_mark: assert property (p_rts_mark) else $error("request-to-send not dropped");

  property p_h5_no_rts;
    (cfg.mode == bt_uart_pkg::TP_H5) |=> !rts_n;
  endproperty
  a_h5_no_rts: assert property (p_h5_no_rts) else $error("flow line used in H5");

  property p_wake;
    sleep && (rxd != st.rxd_prev) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("missed wake event");

endmodule : bt_hci_uart_transport

`default_nettype wire

// [rtl/bt_uart_pkg.sv]
// Constants, carriers and state layout for the HCI serial transport
package bt_uart_pkg;

  // Clock and line rates
  localparam int CLK_HZ      = 125_000_000;
  localparam int BPS_DEFAULT = 115_200;
  localparam int BPS_MIN     = 9_600;
  localparam int BPS_MAX     = 4_000_000;

  // Clocks per bit; the fastest rate rounds up so it never exceeds the ceiling
  localparam logic [15:0] DIV_DEFAULT = 16'(CLK_HZ / BPS_DEFAULT);
  localparam logic [15:0] DIV_MIN     = 16'((CLK_HZ + BPS_MAX - 1) / BPS_MAX);
  localparam logic [15:0] DIV_MAX     = 16'(CLK_HZ / BPS_MIN);
  localparam logic [15:0] DIV_SAT     = 16'hffff;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  // Buffers
  localparam int          FIFO_DEPTH = 1040;
  localparam logic [10:0] FIFO_FULL  = 11'(FIFO_DEPTH);
  localparam logic [10:0] PTR_LAST   = 11'(FIFO_DEPTH - 1);
  localparam logic [10:0] PTR_ONE    = 11'h001;
  localparam logic [10:0] RTS_MARK   = 11'(FIFO_DEPTH - 16);

  // Character layout and special codes
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_ONE   = 3'h1;
  localparam logic [7:0] CH_XON    = 8'h11;
  localparam logic [7:0] CH_XOFF   = 8'h13;
  localparam logic [7:0] SLIP_END  = 8'hc0;
  localparam logic [7:0] SLIP_ESC  = 8'hdb;
  localparam logic [7:0] ESC_END   = 8'hdc;
  localparam logic [7:0] ESC_ESC   = 8'hdd;

  typedef enum logic [2:0] {TP_H4 = 3'b001, TP_EH4 = 3'b010, TP_H5 = 3'b100} transport_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } rx_state_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_STOP = 4'b1000
  } tx_state_t;

  typedef struct packed {logic delim; logic [7:0] data;} fifo_word_t;
  typedef struct packed {logic load; logic [15:0] divisor;} rate_cmd_t;
  typedef struct packed {transport_t mode; logic sw_flow; logic slip_en;} cfg_t;

  typedef struct packed {
    logic [15:0]                  divisor;
    logic                         ab_armed;
    logic                         ab_low;
    logic [15:0]                  ab_cnt;
    logic                         baud_found;
    logic [15:0]                  baud_sel;
    rx_state_t                    rx_state;
    logic [15:0]                  rx_cnt;
    logic [2:0]                   rx_bit;
    logic [7:0]                   rx_shift;
    logic                         rx_esc;
    logic                         paused;
    fifo_word_t [FIFO_DEPTH-1:0]  rx_mem;
    logic [10:0]                  rx_wr;
    logic [10:0]                  rx_rd;
    logic [10:0]                  rx_count;
    logic                         rx_valid;
    fifo_word_t                   rx_word;
    logic                         rx_drop;
    fifo_word_t [FIFO_DEPTH-1:0]  tx_mem;
    logic [10:0]                  tx_wr;
    logic [10:0]                  tx_rd;
    logic [10:0]                  tx_count;
    logic                         tx_room;
    tx_state_t                    tx_state;
    logic [15:0]                  tx_cnt;
    logic [2:0]                   tx_bit;
    logic [7:0]                   tx_shift;
    logic                         tx_esc_pend;
    logic [7:0]                   tx_esc_byte;
    logic                         txd;
    logic                         rts_n;
    logic                         rxd_prev;
    logic                         cts_prev;
    logic                         wake;
  } state_t;

  localparam state_t ST_RESET = '{divisor: DIV_DEFAULT, rx_state: RX_IDLE, tx_state: TX_IDLE,
                                  tx_room: 1'b1, txd: 1'b1, rxd_prev: 1'b1, cts_prev: 1'b1,
                                  default: '0};

endpackage : bt_uart_pkg

// [tb/host_uart_model.sv]
// Host-side serial model: sends characters on rxd and decodes txd
`timescale 1ns/1ps
`default_nettype none

module host_uart_model (
  input  wire logic  clock,
  input  wire logic  txd,
  input  wire logic  rts_n,
  input  wire logic  no_rts,
  output logic       rxd,
  output logic       got_valid,
  output logic [7:0] got_byte,
  output logic       got_stop
);
  int div = 32;

  initial rxd = 1'b1;
  initial got_valid = 1'b0;

  // One character; waits for request-to-send except in H5
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (rts_n !== 1'b0 && !no_rts) @(posedge clock);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= #1 f[i];
      repeat (div) @(posedge clock);
    end
  endtask : send

  // Decode txd at bit midpoints, pulse got_valid after the stop sample
  always
  begin
    @(negedge txd);
    repeat (div / 2) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(posedge clock);
      got_byte[i] = txd;
    end
    repeat (div) @(posedge clock);
    got_stop = txd;
    got_valid <= #1 1'b1;
    @(posedge clock);
    got_valid <= #1 1'b0;
  end
endmodule : host_uart_model
`default_nettype wire

// [tb/bt_hci_uart_transport_bench.sv]
// Self-checking bench for the HCI serial transport
`timescale 1ns/1ps
`default_nettype none

module bt_hci_uart_transport_bench;
  logic                      clock = 1'b0;
  logic                      nrst = 1'b0;
  logic                      rxd, txd, rts_n, baud_found, tx_ready, rx_valid, rx_drop;
  logic                      tx_paused, wake, got_valid, got_stop;
  logic                      cts_n = 1'b0, ab_arm = 1'b0, tx_push = 1'b0;
  logic                      rx_pop = 1'b0, sleep = 1'b0;
  logic [15:0]               baud_sel, bit_divisor;
  logic [7:0]                got_byte, w;
  bt_uart_pkg::cfg_t         cfg = '{bt_uart_pkg::TP_H4, 1'b0, 1'b0};
  bt_uart_pkg::rate_cmd_t    rate_cmd = '0;
  bt_uart_pkg::fifo_word_t   tx_word = '0, rx_word;
  bt_uart_pkg::fifo_word_t   exp_rx[$];
  logic [7:0]                exp_tx[$];
  int                        num_errors = 0, check_count = 0, cycles = 0, n;
  int                        seed = 32'h58f2;

  always #4 clock = ~clock;

  bt_hci_uart_transport uut (.clock(clock), .nrst(nrst), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .rts_n(rts_n), .cfg(cfg), .rate_cmd(rate_cmd), .ab_arm(ab_arm),
    .baud_found(baud_found), .baud_sel(baud_sel), .bit_divisor(bit_divisor),
    .tx_push(tx_push), .tx_word(tx_word), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_pop(rx_pop), .rx_drop(rx_drop), .tx_paused(tx_paused),
    .sleep(sleep), .wake(wake));

  host_uart_model host (.clock(clock), .txd(txd), .rts_n(rts_n),
    .no_rts(cfg.mode == bt_uart_pkg::TP_H5), .rxd(rxd), .got_valid(got_valid),
    .got_byte(got_byte), .got_stop(got_stop));

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (!ok)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step

  task automatic push(input bt_uart_pkg::fifo_word_t v);
    tx_push = 1'b1;
    tx_word = v;
    while (tx_ready !== 1'b1) step(1);
    step(1);
    tx_push = 1'b0;
    step(1);
  endtask : push

  task automatic load(input logic [15:0] d);
    rate_cmd = '{1'b1, d};
    step(1);
    rate_cmd.load = 1'b0;
  endtask : load

  // Random receive stalls
  always @(posedge clock) rx_pop <= #1 1'($random(seed));

  // Watcher: compare each result against the oldest note
  always @(posedge clock)
  begin
    if (got_valid === 1'b1)
      check(exp_tx.size() > 0 && got_byte === exp_tx.pop_front() && got_stop === 1'b1,
            "serial out byte");
    if (rx_valid === 1'b1 && rx_pop === 1'b1)
      check(exp_rx.size() > 0 && rx_word === exp_rx.pop_front(), "received word");
    if (rx_drop === 1'b1)
      check(1'b0, "char dropped");
  end

  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("wrong value at %0t: run timed out", $time);
      give_verdict();
    end
  end

  initial
  begin
    step(4);
    nrst = 1'b1;
    check(bit_divisor === bt_uart_pkg::DIV_DEFAULT && txd === 1'b1 && rts_n === 1'b0
          && tx_ready === 1'b1 && rx_valid === 1'b0, "reset state");
    load(16'h0005);
    check(bit_divisor === bt_uart_pkg::DIV_MIN, "min clamp");
    load(16'hffff);
    check(bit_divisor === bt_uart_pkg::DIV_MAX, "max clamp");
    load(16'h0020);
    check(bit_divisor === 16'h0020, "rate load");
    $display("test rate done");
    // Held by clear-to-send, then prompt start
    cts_n = 1'b1;
    w = 8'($random(seed));
    exp_tx.push_back(w);
    push({1'b0, w});
    step(160);
    check(txd === 1'b1, "sent while cts high");
    cts_n = 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 60)
    begin
      step(1);
      n++;
    end
    check(n <= 48, "late start after cts");
    for (int i = 0; i < 4; i++)
    begin
      w = 8'($random(seed));
      exp_tx.push_back(w);
      push({1'b0, w});
    end
    wait (exp_tx.size() == 0);
    for (int i = 0; i < 4; i++)
    begin
      w = 8'($random(seed));
      exp_rx.push_back({1'b0, w});
      host.send(w);
    end
    wait (exp_rx.size() == 0);
    $display("test transfer done");
    // Software flow control
    cfg.sw_flow = 1'b1;
    host.send(bt_uart_pkg::CH_XOFF);
    step(4);
    check(tx_paused === 1'b1, "xoff pause");
    exp_tx.push_back(8'h5a);
    push({1'b0, 8'h5a});
    step(400);
    check(exp_tx.size() == 1, "sent while paused");
    host.send(bt_uart_pkg::CH_XON);
    step(4);
    check(tx_paused === 1'b0, "xon resume");
    wait (exp_tx.size() == 0);
    cfg.sw_flow = 1'b0;
    $display("test flow done");
    // Line-rate detection on a start bit only
    ab_arm = 1'b1;
    step(1);
    ab_arm = 1'b0;
    n = 0;
    fork
      host.send(8'hff);
      while (baud_found !== 1'b1 && n < 400)
      begin
        step(1);
        n++;
      end
    join
    check(n < 400 && baud_sel >= 16'h001f && baud_sel <= 16'h0021
          && bit_divisor === baud_sel, "detected rate");
    load(16'h0020);
    $display("test detect done");
    // Wake on clear-to-send change while asleep
    sleep = 1'b1;
    step(2);
    cts_n = 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 4)
    begin
      step(1);
      n++;
    end
    check(n < 4, "wake missing");
    sleep = 1'b0;
    $display("test wake done");
    // H5 with SLIP: lines ignored, escaping both ways
    cfg = '{bt_uart_pkg::TP_H5, 1'b0, 1'b1};
    step(2);
    check(rts_n === 1'b0, "rts in h5");
    exp_tx = '{bt_uart_pkg::SLIP_ESC, bt_uart_pkg::ESC_END, bt_uart_pkg::SLIP_END};
    push({1'b0, bt_uart_pkg::SLIP_END});
    push({1'b1, 8'h00});
    wait (exp_tx.size() == 0);
    exp_rx = '{{1'b0, bt_uart_pkg::SLIP_END}, {1'b1, bt_uart_pkg::SLIP_END}};
    host.send(bt_uart_pkg::SLIP_ESC);
    host.send(bt_uart_pkg::ESC_END);
    host.send(bt_uart_pkg::SLIP_END);
    wait (exp_rx.size() == 0);
    $display("test slip done");
    step(4);
    give_verdict();
  end
endmodule : bt_hci_uart_transport_bench
`default_nettype wire
